// *** err_sideband_defs.vh ***
// Constants for the error and thermal sideband block.
`ifndef ERR_SIDEBAND_DEFS_VH
`define ERR_SIDEBAND_DEFS_VH
`define REF_CLK_MHZ        200
`define BASE_REF_MHZ       100
`define PULSE_BASE_CYCLES  16
`define PULSE_CYCLES       ((`PULSE_BASE_CYCLES * `REF_CLK_MHZ) / `BASE_REF_MHZ)
`define SEV_CORRECTED      0
`define SEV_NONFATAL       1
`define SEV_FATAL          2
`define SEV_WIDTH          3
`endif

// *** pin_sync3.v ***
// Three-stage pin synchroniser with agreement filter.
`timescale 1ns/10ps
module pin_sync3 #(
  parameter RESET_VAL = 1'b1
) (
  // Clock and reset
  input  wire clk_i,
  input  wire rst_n_i,
  // Pin and filtered level
  input  wire pin_i,
  output wire level_o
);
  reg s1_r;
  reg s2_r;
  reg s3_r;
  reg level_r;

  // The first stage feeds only the second; the filter looks at stages two and three.
  always @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      s1_r    <= RESET_VAL;
      s2_r    <= RESET_VAL;
      s3_r    <= RESET_VAL;
      level_r <= RESET_VAL;
    end
    else
    begin
      s1_r <= pin_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r)
        level_r <= s3_r;
    end
  end

  assign level_o = level_r;
endmodule

// *** error_thermal_sideband.v ***
// Error and thermal sideband pin logic for the processor side.
//
// Functional notes
// - Assert fatal line on unrecoverable errors
// - Fatal line is open-drain, wired-OR shared
// - External fatal assertion raises machine check
// - Ignore fatal line input before power good
// - Pulse error drives fatal line sixteen base clocks
// - Held error keeps line until reset
// - Three I/O severity outputs, bit meanings
// - External thermal input throttles tied channels
// - Output mode holds thermal line while hot
// - Line ch01 for channels 0,1; ch23 for 2,3
// - Notify output signals checks when enabled
`timescale 1ns/10ps
`include "err_sideband_defs.vh"
module error_thermal_sideband #(
  parameter SEV_W      = `SEV_WIDTH,
  parameter PULSE_CYC  = `PULSE_CYCLES
) (
  // Clock and reset
  input  wire             clk_i,
  input  wire             rst_n_i,
  input  wire             warm_reset_i,
  input  wire             power_good_in_i,
  // Internal error events
  input  wire             mc_pulse_err_i,
  input  wire             held_err_i,
  input  wire [SEV_W-1:0] io_sev_event_i,
  input  wire             enhanced_check_reporting_i,
  // Fatal line, open drain
  input  wire             fatal_error_out_n_i,
  output wire             fatal_error_out_n_o,
  output wire             fatal_error_out_n_oe_o,
  // Severity outputs
  output wire [SEV_W-1:0] io_unit_severity_n_o,
  // Machine check
  output wire             machine_check_exc_o,
  output wire             machine_check_notify_n_o,
  // Memory thermal lines
  input  wire             mem_hot_out_mode_i,
  input  wire [1:0]       branch_hot_i,
  input  wire             mem_thermal_ch01_n_i,
  input  wire             mem_thermal_ch23_n_i,
  output wire             mem_thermal_ch01_n_o,
  output wire             mem_thermal_ch23_n_o,
  output wire             mem_thermal_ch01_n_oe_o,
  output wire             mem_thermal_ch23_n_oe_o,
  output wire [3:0]       channel_throttle_o
);
  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  wire fatal_lvl_n;
  wire pg_lvl;
  wire hot01_lvl_n;
  wire hot23_lvl_n;

  pin_sync3 #(.RESET_VAL(1'b1)) u_sync_fatal (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .pin_i   (fatal_error_out_n_i),
    .level_o (fatal_lvl_n)
  );
  pin_sync3 #(.RESET_VAL(1'b0)) u_sync_pg (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .pin_i   (power_good_in_i),
    .level_o (pg_lvl)
  );
  pin_sync3 #(.RESET_VAL(1'b1)) u_sync_h01 (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .pin_i   (mem_thermal_ch01_n_i),
    .level_o (hot01_lvl_n)
  );
  pin_sync3 #(.RESET_VAL(1'b1)) u_sync_h23 (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .pin_i   (mem_thermal_ch23_n_i),
    .level_o (hot23_lvl_n)
  );

  // ------------------------------------------------------------
  // Local constants
  // ------------------------------------------------------------
  // One-hot states of the fatal line driver.
  localparam [2:0] ST_IDLE  = 3'b001;
  localparam [2:0] ST_PULSE = 3'b010;
  localparam [2:0] ST_HELD  = 3'b100;
  // Width of the pulse counter; PULSE_CYC must fit in it.
  localparam       CNT_W    = 8;
  // A pull of our own stays visible on the synchronised pin for four
  // cycles after release; the mask outlives the drive by one more so
  // that a slow pull-up cannot fake a foreign assertion.
  localparam       MASK_LEN = 5;

  // ------------------------------------------------------------
  // Helper functions
  // ------------------------------------------------------------
  // An active-low level is asserted when it reads zero.
  function line_low;
    input lvl_n;
    begin
      line_low = ~lvl_n;
    end
  endfunction

  // A pin pair throttles both of its channels unless the pull is our own.
  function [1:0] pair_throttle;
    input lvl_n;
    input own_pull;
    begin
      pair_throttle = {2{line_low(lvl_n) & ~own_pull}};
    end
  endfunction

  // Our own pull, now or within the trailing history.
  function own_or_recent;
    input                now;
    input [MASK_LEN-1:0] hist;
    begin
      own_or_recent = now | (|hist);
    end
  endfunction

  // ------------------------------------------------------------
  // State and counters
  // ------------------------------------------------------------
  reg [2:0]          state_r;
  reg [2:0]          state_nxt;
  reg [CNT_W-1:0]    pulse_cnt_r;
  reg [CNT_W-1:0]    pulse_cnt_nxt;
  reg                drive_r;
  reg                drive_nxt;
  reg [MASK_LEN-1:0] own_hist_r;
  reg [MASK_LEN-1:0] hot01_hist_r;
  reg [MASK_LEN-1:0] hot23_hist_r;
  reg                mce_r;
  reg [SEV_W-1:0]    sev_n_r;
  reg [1:0]          hot_out_r;
  reg [3:0]          throttle_r;
  wire               clear_all;
  wire               own_mask;
  wire               hot01_mask;
  wire               hot23_mask;
  wire               ext_fatal;

  assign clear_all = ~rst_n_i | warm_reset_i;

  // ------------------------------------------------------------
  // Pulse counter
  // ------------------------------------------------------------
  // A new pulse error restarts the full count.
  always @*
  begin
    pulse_cnt_nxt = pulse_cnt_r;
    if (mc_pulse_err_i)
      pulse_cnt_nxt = PULSE_CYC[CNT_W-1:0];
    else if (pulse_cnt_r != {CNT_W{1'b0}})
      pulse_cnt_nxt = pulse_cnt_r - {{(CNT_W-1){1'b0}}, 1'b1};
  end

  always @(posedge clk_i)
  begin
    if (clear_all)
      pulse_cnt_r <= {CNT_W{1'b0}};
    else
      pulse_cnt_r <= pulse_cnt_nxt;
  end

  // ------------------------------------------------------------
  // Fatal line state machine
  // ------------------------------------------------------------
  // A held error wins over a pulse; only a reset ends it.
  always @*
  begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:
      begin
        if (held_err_i)
          state_nxt = ST_HELD;
        else if (mc_pulse_err_i)
          state_nxt = ST_PULSE;
      end
      ST_PULSE:
      begin
        if (held_err_i)
          state_nxt = ST_HELD;
        else if (pulse_cnt_nxt == {CNT_W{1'b0}})
          state_nxt = ST_IDLE;
      end
      ST_HELD:
        state_nxt = ST_HELD;
      default:
        state_nxt = ST_IDLE;
    endcase
    drive_nxt = (state_nxt != ST_IDLE);
  end

  always @(posedge clk_i)
  begin
    if (clear_all)
    begin
      state_r <= ST_IDLE;
      drive_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      drive_r <= drive_nxt;
    end
  end

  // ------------------------------------------------------------
  // Own pull history
  // ------------------------------------------------------------
  // Only a full reset clears the history: after a warm reset a line we
  // just released still reads low in the synchronisers for a while.
  always @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      own_hist_r   <= {MASK_LEN{1'b0}};
      hot01_hist_r <= {MASK_LEN{1'b0}};
      hot23_hist_r <= {MASK_LEN{1'b0}};
    end
    else
    begin
      own_hist_r   <= {own_hist_r[MASK_LEN-2:0], drive_r};
      hot01_hist_r <= {hot01_hist_r[MASK_LEN-2:0], hot_out_r[0]};
      hot23_hist_r <= {hot23_hist_r[MASK_LEN-2:0], hot_out_r[1]};
    end
  end

  assign own_mask   = own_or_recent(drive_r, own_hist_r);
  assign hot01_mask = own_or_recent(hot_out_r[0], hot01_hist_r);
  assign hot23_mask = own_or_recent(hot_out_r[1], hot23_hist_r);

  // ------------------------------------------------------------
  // Machine check
  // ------------------------------------------------------------
  assign ext_fatal = pg_lvl & line_low(fatal_lvl_n) & ~own_mask;

  always @(posedge clk_i)
  begin
    if (clear_all)
      mce_r <= 1'b0;
    else
      mce_r <= ext_fatal | mc_pulse_err_i | held_err_i;
  end

  // ------------------------------------------------------------
  // Severity outputs
  // ------------------------------------------------------------
  always @(posedge clk_i)
  begin
    if (clear_all)
      sev_n_r <= {SEV_W{1'b1}};
    else
      sev_n_r <= ~io_sev_event_i;
  end

  // ------------------------------------------------------------
  // Memory thermal lines
  // ------------------------------------------------------------
  always @(posedge clk_i)
  begin
    if (clear_all)
      hot_out_r <= 2'b00;
    else
      hot_out_r <= mem_hot_out_mode_i ? branch_hot_i : 2'b00;
  end

  // Throttle is suppressed for a branch we pull ourselves, so that our
  // own hot indication does not slow that branch down.
  always @(posedge clk_i)
  begin
    if (clear_all)
      throttle_r <= 4'h0;
    else
      throttle_r <= {pair_throttle(hot23_lvl_n, hot23_mask), pair_throttle(hot01_lvl_n, hot01_mask)};
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  // Open drain: only ever pull low, never drive high.
  assign fatal_error_out_n_o      = 1'b0;
  assign fatal_error_out_n_oe_o   = drive_r;
  assign io_unit_severity_n_o     = sev_n_r;
  assign machine_check_exc_o      = mce_r;
  assign machine_check_notify_n_o = ~(mce_r & enhanced_check_reporting_i);
  assign mem_thermal_ch01_n_o     = 1'b0;
  assign mem_thermal_ch23_n_o     = 1'b0;
  assign mem_thermal_ch01_n_oe_o  = hot_out_r[0];
  assign mem_thermal_ch23_n_oe_o  = hot_out_r[1];
  assign channel_throttle_o       = throttle_r;
endmodule

// *** sideband_checker_properties.sv ***
// Checker and bind for the sideband pin logic.
`timescale 1ns/10ps
module sideband_checker #(parameter PULSE_CYC = 32) (
  input wire       clk_i, rst_n_i, warm_reset_i, power_good_in_i, mc_pulse_err_i, held_err_i,
  input wire       enhanced_check_reporting_i, fatal_error_out_n_i, fatal_error_out_n_oe_o,
  input wire       machine_check_exc_o, machine_check_notify_n_o,
  input wire [2:0] io_sev_event_i, io_unit_severity_n_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // Warm reset legally drops a held pull, so the run must be free of it.
  sequence held_run;
    held_err_i && !warm_reset_i ##1 !warm_reset_i [*8];
  endsequence
  sequence ext_pull;
    (!fatal_error_out_n_i && power_good_in_i && !fatal_error_out_n_oe_o) [*8];
  endsequence
  pulse_on_a: assert property (mc_pulse_err_i && !warm_reset_i |=> fatal_error_out_n_oe_o && machine_check_exc_o)
    else $error("pulse not seen");
  pulse_len_a: assert property ($fell(fatal_error_out_n_oe_o) && !$past(warm_reset_i)
    |-> $past(mc_pulse_err_i, PULSE_CYC + 1)) else $error("pulse length");
  held_keep_a: assert property (held_run |-> fatal_error_out_n_oe_o) else $error("held pull lost");
  warm_clr_a: assert property (warm_reset_i && !mc_pulse_err_i && !held_err_i |=> !fatal_error_out_n_oe_o)
    else $error("warm reset kept pull");
  sev_map_a: assert property ($past(rst_n_i) && !$past(warm_reset_i)
    |-> io_unit_severity_n_o == ~$past(io_sev_event_i)) else $error("severity");
  ext_mce_a: assert property (ext_pull |-> machine_check_exc_o) else $error("no outside check");
  pg_gate_a: assert property ((!power_good_in_i && !mc_pulse_err_i
    && !held_err_i && !fatal_error_out_n_oe_o) [*8] |-> !machine_check_exc_o) else $error("sampled early");
  notify_map_a: assert property
    (machine_check_notify_n_o == !(machine_check_exc_o && enhanced_check_reporting_i)) else $error("notify");
endmodule
bind error_thermal_sideband sideband_checker #(.PULSE_CYC(PULSE_CYC)) chk_u (.*);

// *** platform_model.sv ***
// Far-side model: pull-ups and outside agents on the shared lines.
`timescale 1ns/10ps
module platform_model (
  input  wire fatal_error_out_n_oe_o, mem_thermal_ch01_n_oe_o, mem_thermal_ch23_n_oe_o, fx_i, t01_i, t23_i,
  output wire fatal_error_out_n_i, mem_thermal_ch01_n_i, mem_thermal_ch23_n_i
);
  // A released line floats high on its pull-up; any puller wins.
  assign fatal_error_out_n_i  = !(fatal_error_out_n_oe_o || fx_i);
  assign mem_thermal_ch01_n_i = !(mem_thermal_ch01_n_oe_o || t01_i);
  assign mem_thermal_ch23_n_i = !(mem_thermal_ch23_n_oe_o || t23_i);
endmodule

// *** error_thermal_sideband_tb_top.sv ***
// Self-checking bench for the sideband pin logic.
`timescale 1ns/10ps
module error_thermal_sideband_tb_top;
  reg        clk_i = 1'h0, rst_n_i = 1'h0, warm_reset_i = 1'h0, power_good_in_i = 1'h0, held_err_i = 1'h0;
  reg        mc_pulse_err_i = 1'h0, enhanced_check_reporting_i = 1'h0, mem_hot_out_mode_i = 1'h0;
  reg        fx_i = 1'h0, t01_i = 1'h0, t23_i = 1'h0;
  reg  [2:0] io_sev_event_i = 3'h0;
  reg  [1:0] branch_hot_i = 2'h0;
  wire       fatal_error_out_n_i, fatal_error_out_n_o, fatal_error_out_n_oe_o, machine_check_exc_o;
  wire       machine_check_notify_n_o, mem_thermal_ch01_n_i, mem_thermal_ch23_n_i, mem_thermal_ch01_n_o;
  wire       mem_thermal_ch23_n_o, mem_thermal_ch01_n_oe_o, mem_thermal_ch23_n_oe_o;
  wire [2:0] io_unit_severity_n_o;
  wire [3:0] channel_throttle_o;
  integer    fail_count = 0, checked = 0, n;
  error_thermal_sideband dut (.*);
  platform_model pm (.*);
  always #2.5 clk_i = !clk_i;
  task tick(input integer k);
    repeat (k) @(negedge clk_i);
  endtask
  task chk(input [7:0] g, e);
    begin
      checked = checked + 1;
      if (g !== e)
      begin
        fail_count = fail_count + 1;
        $display("wrong value %0t %h %h", $time, g, e);
      end
    end
  endtask
  task t_pg;
    begin
      fx_i = 1'h1;
      tick(12);
      chk(machine_check_exc_o, 8'h00);
      power_good_in_i = 1'h1;
      enhanced_check_reporting_i = 1'h1;
      tick(12);
      chk({machine_check_exc_o, machine_check_notify_n_o}, 8'h02);
      fx_i = 1'h0;
      tick(8);
      $display("pg end");
    end
  endtask
  task t_pulse;
    begin
      mc_pulse_err_i = 1'h1;
      tick(1);
      mc_pulse_err_i = 1'h0;
      n = 0;
      repeat (40)
      begin
        n = n + fatal_error_out_n_oe_o;
        tick(1);
      end
      chk(n, 8'h20);
      $display("pulse end");
    end
  endtask
  task t_held;
    begin
      held_err_i = 1'h1;
      tick(1);
      held_err_i = 1'h0;
      tick(40);
      chk({fatal_error_out_n_oe_o, fatal_error_out_n_i}, 8'h02);
      warm_reset_i = 1'h1;
      tick(1);
      warm_reset_i = 1'h0;
      io_sev_event_i = 3'h5;
      tick(2);
      chk({fatal_error_out_n_oe_o, io_unit_severity_n_o}, 8'h02);
      $display("held end");
    end
  endtask
  task t_mem;
    begin
      t23_i = 1'h1;
      tick(10);
      chk(channel_throttle_o, 8'h0c);
      t23_i = 1'h0;
      mem_hot_out_mode_i = 1'h1;
      branch_hot_i = 2'h1;
      tick(2);
      chk({mem_thermal_ch23_n_i, mem_thermal_ch01_n_i}, 8'h02);
      chk({fatal_error_out_n_o, mem_thermal_ch01_n_o, mem_thermal_ch23_n_o}, 8'h00);
      $display("thermal end");
    end
  endtask
  task complete_run;
    begin
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  initial
  begin
    tick(8);
    rst_n_i = 1'h1;
    chk(io_unit_severity_n_o, 8'h07);
    t_pg;
    t_pulse;
    t_held;
    t_mem;
    complete_run;
  end
  initial
  begin
    #5000;
    fail_count = fail_count + 1;
    complete_run;
  end
endmodule
